// *** logic/low_power_mode_controller.sv ***
// Run, background, wait and stop mode sequencing with AXI4-Lite registers
// Assumes one clock aclk; pins and wake sources arrive asynchronously,
// CPU and debug host strobes are synchronous one-cycle pulses
//
// Functional notes
// - Background mode on low mode pin at reset, command, instruction, breakpoints.
// - In background mode the CPU is suspended awaiting debug commands.
// - Non-intrusive commands are accepted in run and background mode.
// - CPU register access, trace and resume work only in background mode.
// - Wait stops the CPU clock and clears the interrupt mask bit.
// - An interrupt in wait resumes with stacking into the service routine.
// - In wait only background and status commands; status reports error.
// - Stop with stop disabled gives an illegal opcode reset.
// - Stop with debug allowed enters shallow stop keeping debug enabled.
// - Both low-voltage bits set at stop: shallow stop, regulator active.
// - Otherwise partial powerdown control picks deep or shallow stop.
// - Shallow stop halts clocks but keeps all state, RAM and pins.
// - Shallow stop exits on reset pin, pin interrupts and listed peripherals.
// - Reset pin exit fetches reset vector; interrupt exit its own vector.
// - Debug allowed at stop keeps debug clock and full regulation.
// - Stop with debug: background command wakes; status reports error.
// - Deep stop latches pin controls and powers down all but RAM.
// - Deep stop exits on reset pin, enabled RTC, or legacy IRQ pin.
// - Deep stop wake restarts as power-on, held while supply low.
// - Deep wake sets flag, pins stay latched until acknowledge written.
// - Opening the latches hands pins back to port or peripheral control.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "lpm_cfg.svh"
module low_power_mode_controller (
	// Clock, reset, enable
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	// AXI4-Lite slave
	input  wire logic [7:0]    s_awaddr,
	input  wire logic          s_awvalid,
	output logic               s_awready,
	input  wire logic [31:0]   s_wdata,
	input  wire logic [3:0]    s_wstrb,
	input  wire logic          s_wvalid,
	output logic               s_wready,
	output logic [1:0]         s_bresp,
	output logic               s_bvalid,
	input  wire logic          s_bready,
	input  wire logic [7:0]    s_araddr,
	input  wire logic          s_arvalid,
	output logic               s_arready,
	output logic [31:0]        s_rdata,
	output logic [1:0]         s_rresp,
	output logic               s_rvalid,
	input  wire logic          s_rready,
	// Asynchronous pins and wake sources
	input  wire logic          debug_mode_select_pin,
	input  wire logic          reset_pin_n,
	input  wire logic          irq_pin_n,
	input  wire logic [7:0]    port_a_pin_interrupts,
	input  wire logic [7:0]    port_b_pin_interrupts,
	input  wire logic [7:0]    port_d_pin_interrupts,
	input  wire logic          low_supply_detector,
	input  wire logic          low_supply_warning,
	input  wire logic          adc_done,
	input  wire logic          rtc_wake,
	input  wire logic          can_wake,
	input  wire logic          sci_rx_irq,
	// CPU core
	input  wire logic          wait_insn,
	input  wire logic          stop_insn,
	input  wire logic          enter_debug_instruction,
	input  wire logic          irq_req,
	output logic               cpu_clk_en,
	output logic               cpu_reset,
	output logic               imask_clear,
	output logic               irq_stack_start,
	output logic               illegal_reset,
	output logic               cpu_step,
	// Debug host and breakpoints
	input  wire logic          bdc_breakpoint,
	input  wire logic          dbg_breakpoint,
	input  wire logic          cmd_valid,
	input  lpm_pkg::cmd_t      cmd,
	input  wire logic          cmd_data,
	output logic               cmd_ok,
	output logic               cmd_err,
	output logic               cmd_reject,
	// Power and pins
	output logic               periph_clk_en,
	output logic               debug_clk_en,
	output logic               regulator_full,
	output logic               power_off,
	output logic               pin_hold,
	output logic               lv_trip_high
);
	import lpm_pkg::*;

	localparam int NW = `LPM_NWAKE;

	mode_t            state_q;
	mode_t            state_d;
	logic [NW-1:0]    raw;
	logic [NW-1:0]    sync1_q;
	logic [NW-1:0]    sync2_q;
	logic [NW-1:0]    sync3_q;
	logic [NW-1:0]    wk_q;
	logic [7:0]       ctrl_q;
	logic             dbg_allow_q;
	logic             flag_q;
	logic             hold_q;
	logic             reg_keep_q;
	logic [1:0]       boot_cnt_q;
	logic             aw_got_q;
	logic             w_got_q;
	logic [7:0]       awaddr_q;
	logic [31:0]      wdata_q;
	logic             wstrb0_q;
	logic             do_wr;
	logic             ack_wr;
	logic             bg_req;
	logic             deep_wake;
	logic             s3_wake;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `LPM_OFF_CTRL) || (a == `LPM_OFF_STATUS) ||
			(a == `LPM_OFF_ACK) || (a == `LPM_OFF_WAKE);
	endfunction

	// Inversion sits before the first stage so all sources are active high
	assign raw = {~debug_mode_select_pin, sci_rx_irq, can_wake, rtc_wake,
		adc_done, low_supply_warning, low_supply_detector,
		port_d_pin_interrupts, port_b_pin_interrupts,
		port_a_pin_interrupts, ~irq_pin_n, ~reset_pin_n};

	// Stages run through reset so the mode pin is settled at release
	always_ff @(posedge aclk) begin
		if (ce) begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// A rise counts only once stages two and three agree; any disagreement clears at once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wk_q <= '0;
		end else if (ce) begin
			wk_q <= (sync2_q & sync3_q) | (wk_q & ~(sync2_q ^ sync3_q));
		end
	end

	assign bg_req = enter_debug_instruction || bdc_breakpoint ||
		dbg_breakpoint || (cmd_valid && cmd == CMD_BACKGROUND);
	// Stop3 exit sources; all but the mode pin
	assign s3_wake = |wk_q[NW-2:0];
	assign deep_wake = wk_q[`LPM_W_RSTPIN] ||
		(ctrl_q[`LPM_B_RTCWK] && wk_q[`LPM_W_RTC]) ||
		(ctrl_q[`LPM_B_LEGIRQ] && wk_q[`LPM_W_IRQ]);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_BOOT: begin
				// Held in reset while the supply is low, like power-on
				if (boot_cnt_q == `LPM_BOOT_CYC && !wk_q[`LPM_W_LVD]) begin
					state_d = wk_q[`LPM_W_MODE] ? ST_BKGD : ST_RUN;
				end
			end
			ST_RUN: begin
				if (bg_req) begin
					state_d = ST_BKGD;
				end else if (stop_insn && ctrl_q[`LPM_B_STOP]) begin
					if (dbg_allow_q) begin
						state_d = ST_STOP3;
					end else if (ctrl_q[`LPM_B_LVDON] && ctrl_q[`LPM_B_LVDSTOP]) begin
						state_d = ST_STOP3;
					end else begin
						state_d = ctrl_q[`LPM_B_PARTIAL_POWERDOWN_CTRL] ? ST_STOP2 : ST_STOP3;
					end
				end else if (wait_insn) begin
					state_d = ST_WAIT;
				end
			end
			ST_BKGD: begin
				if (cmd_valid && cmd == CMD_GO) begin
					state_d = ST_RUN;
				end
			end
			ST_WAIT: begin
				if (cmd_valid && cmd == CMD_BACKGROUND) begin
					state_d = ST_BKGD;
				end else if (wk_q[`LPM_W_RSTPIN]) begin
					state_d = ST_BOOT;
				end else if (irq_req) begin
					state_d = ST_RUN;
				end
			end
			ST_STOP3: begin
				if (dbg_allow_q && cmd_valid && cmd == CMD_BACKGROUND) begin
					state_d = ST_BKGD;
				end else if (wk_q[`LPM_W_RSTPIN]) begin
					state_d = ST_BOOT;
				end else if (s3_wake) begin
					state_d = ST_RUN;
				end
			end
			ST_STOP2: begin
				if (deep_wake) begin
					state_d = ST_BOOT;
				end
			end
			default: state_d = ST_BOOT;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q    <= ST_BOOT;
			boot_cnt_q <= 2'h0;
		end else if (ce) begin
			state_q    <= state_d;
			boot_cnt_q <= (state_q == ST_BOOT && boot_cnt_q != `LPM_BOOT_CYC) ?
				boot_cnt_q + 2'h1 : (state_q == ST_BOOT ? boot_cnt_q : 2'h0);
		end
	end

	// CPU side strobes, all registered one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			imask_clear     <= 1'b0;
			irq_stack_start <= 1'b0;
			illegal_reset   <= 1'b0;
			cpu_step        <= 1'b0;
		end else if (ce) begin
			imask_clear     <= state_q == ST_RUN && state_d == ST_WAIT;
			irq_stack_start <= (state_q == ST_WAIT || state_q == ST_STOP3) &&
				state_d == ST_RUN;
			illegal_reset   <= state_q == ST_RUN && !bg_req && stop_insn &&
				!ctrl_q[`LPM_B_STOP];
			cpu_step        <= state_q == ST_BKGD && cmd_valid &&
				cmd == CMD_TRACE;
		end
	end

	// Debug command answers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_ok      <= 1'b0;
			cmd_err     <= 1'b0;
			cmd_reject  <= 1'b0;
			dbg_allow_q <= 1'b0;
		end else if (ce) begin
			cmd_ok     <= 1'b0;
			cmd_err    <= 1'b0;
			cmd_reject <= 1'b0;
			if (state_q == ST_STOP2 && state_d == ST_BOOT) begin
				dbg_allow_q <= 1'b0;
			end
			if (cmd_valid) begin
				case (state_q)
					ST_RUN, ST_BKGD: begin
						if (cmd <= CMD_BACKGROUND || state_q == ST_BKGD) begin
							cmd_ok <= 1'b1;
							if (cmd == CMD_DBGREG) begin
								dbg_allow_q <= cmd_data;
							end
						end else begin
							cmd_reject <= 1'b1;
						end
					end
					ST_WAIT, ST_STOP3: begin
						if (cmd == CMD_MEM_STAT) begin
							cmd_err <= 1'b1;
						end else if (cmd == CMD_BACKGROUND &&
							(state_q == ST_WAIT || dbg_allow_q)) begin
							cmd_ok <= 1'b1;
						end else begin
							cmd_reject <= 1'b1;
						end
					end
					default: cmd_reject <= 1'b1;
				endcase
			end
		end
	end

	// Regulator choice is caught at the stop instruction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_keep_q <= 1'b0;
		end else if (ce && state_q == ST_RUN && state_d == ST_STOP3) begin
			reg_keep_q <= dbg_allow_q ||
				(ctrl_q[`LPM_B_LVDON] && ctrl_q[`LPM_B_LVDSTOP]);
		end
	end

	// Pins stay latched from deep stop entry until acknowledged after wake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
			hold_q <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_STOP2 && state_d == ST_BOOT) begin
				flag_q <= 1'b1;
			end else if (ack_wr) begin
				flag_q <= 1'b0;
			end
			if (state_d == ST_STOP2) begin
				hold_q <= 1'b1;
			end else if (ack_wr && state_q != ST_STOP2) begin
				hold_q <= 1'b0;
			end
		end
	end

	// Shallow stop gates clocks and drops full regulation unless reg_keep_q is set; no state is touched
	assign cpu_clk_en     = state_q == ST_RUN;
	assign cpu_reset      = state_q == ST_BOOT;
	assign periph_clk_en  = state_q != ST_STOP3 &&
		state_q != ST_STOP2;
	assign debug_clk_en   = state_q != ST_STOP2 &&
		(state_q != ST_STOP3 || dbg_allow_q);
	assign regulator_full = (state_q != ST_STOP3 && state_q != ST_STOP2) ||
		(state_q == ST_STOP3 && reg_keep_q);
	assign power_off      = state_q == ST_STOP2;
	assign pin_hold       = hold_q;
	assign lv_trip_high   = ctrl_q[`LPM_B_TRIPHI];

	// AXI4-Lite write path; address and data may come in either order
	assign s_awready = ce && !aw_got_q && !s_bvalid;
	assign s_wready  = ce && !w_got_q && !s_bvalid;
	assign do_wr     = aw_got_q && w_got_q && !s_bvalid;
	assign ack_wr    = ce && do_wr && awaddr_q == `LPM_OFF_ACK &&
		wstrb0_q && wdata_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb0_q <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp  <= 2'h0;
		end else if (ce) begin
			if (s_awvalid && s_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= {s_awaddr[7:2], 2'h0};
			end
			if (s_wvalid && s_wready) begin
				w_got_q  <= 1'b1;
				wdata_q  <= s_wdata;
				wstrb0_q <= s_wstrb[0];
			end
			if (do_wr) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp  <= mapped(awaddr_q) ? 2'h0 : 2'h2;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `LPM_CTRL_RST;
		end else if (ce) begin
			if (state_q == ST_STOP2 && state_d == ST_BOOT) begin
				ctrl_q <= `LPM_CTRL_RST;
			end else if (do_wr && awaddr_q == `LPM_OFF_CTRL && wstrb0_q) begin
				ctrl_q <= {1'b0, wdata_q[6:0]};
			end
		end
	end

	// Read path answers one cycle after the address is taken
	assign s_arready = ce && !s_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= 2'h0;
		end else if (ce) begin
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp  <= mapped({s_araddr[7:2], 2'h0}) ? 2'h0 : 2'h2;
				case ({s_araddr[7:2], 2'h0})
					`LPM_OFF_CTRL:   s_rdata <= {24'h00_0000, ctrl_q};
					`LPM_OFF_STATUS: s_rdata <= {26'h000_0000, dbg_allow_q,
						hold_q, flag_q, state_q};
					`LPM_OFF_WAKE:   s_rdata <= wk_q[31:0];
					default:         s_rdata <= 32'h0000_0000;
				endcase
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	logic run_stop;
	assign run_stop = state_q == ST_RUN && !bg_req && stop_insn &&
		ctrl_q[`LPM_B_STOP];

	AST_ILLEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && state_q == ST_RUN && !bg_req && stop_insn &&
		!ctrl_q[`LPM_B_STOP] |=> illegal_reset && state_q == ST_RUN)
		else $error("stop while disabled gave no illegal reset");
	AST_DBG_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && run_stop && dbg_allow_q |=>
		state_q == ST_STOP3 && debug_clk_en && regulator_full)
		else $error("debug stop did not keep debug running");
	AST_LV_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && run_stop && !dbg_allow_q && ctrl_q[`LPM_B_LVDON] &&
		ctrl_q[`LPM_B_LVDSTOP] |=> state_q == ST_STOP3 && regulator_full)
		else $error("low voltage stop lost regulator");
	AST_DEEP_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && run_stop && !dbg_allow_q && !ctrl_q[`LPM_B_LVDSTOP] |=>
		(state_q == ST_STOP2) == $past(ctrl_q[`LPM_B_PARTIAL_POWERDOWN_CTRL]))
		else $error("wrong stop level selected");
	AST_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && state_q == ST_RUN && !bg_req && !stop_insn && wait_insn |=>
		imask_clear && !cpu_clk_en)
		else $error("wait entry wrong");
	AST_STAT_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && cmd_valid && cmd == CMD_MEM_STAT &&
		(state_q == ST_WAIT || state_q == ST_STOP3) |=> cmd_err && !cmd_ok)
		else $error("status command in low power did not error");
	AST_ACT_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && cmd_valid && cmd == CMD_CPUREG && state_q == ST_RUN |=>
		cmd_reject)
		else $error("active only command accepted in run");
	AST_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_q && !ack_wr |=> flag_q && hold_q)
		else $error("powerdown flag or hold dropped early");
	AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_STOP2 |-> pin_hold && power_off && !periph_clk_en)
		else $error("deep stop without pin hold");
	AST_SUSPEND: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_BKGD |-> !cpu_clk_en)
		else $error("cpu clocked in background mode");
	AST_DEEP_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && state_q == ST_STOP2 && wk_q[`LPM_W_RSTPIN] |=>
		state_q == ST_BOOT && flag_q && ctrl_q == `LPM_CTRL_RST)
		else $error("deep stop wake did not restart");

	COV_WAIT_IRQ: cover property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_WAIT ##1 irq_stack_start);
	COV_STOP3_WAKE: cover property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_STOP3 ##1 state_q == ST_RUN);
	COV_DEEP_ACK: cover property (@(posedge aclk) disable iff (!aresetn)
		flag_q ##1 !flag_q && !hold_q);
endmodule

// *** logic/lpm_cfg.svh ***
// Offsets, field positions, reset values and counts of the mode controller
// Assumes inclusion by its bare name from the design files
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
`define LPM_OFF_CTRL    8'h00
`define LPM_OFF_STATUS  8'h04
`define LPM_OFF_ACK     8'h08
`define LPM_OFF_WAKE    8'h0C
`define LPM_CTRL_RST    8'h00
`define LPM_B_STOP      0
`define LPM_B_LVDON     1
`define LPM_B_LVDSTOP   2
`define LPM_B_PARTIAL_POWERDOWN_CTRL      3
`define LPM_B_RTCWK     4
`define LPM_B_LEGIRQ    5
`define LPM_B_TRIPHI    6
`define LPM_S_FLAG      3
`define LPM_S_HOLD      4
`define LPM_S_DBGEN     5
`define LPM_NWAKE       33
`define LPM_W_RSTPIN    0
`define LPM_W_IRQ       1
`define LPM_W_LVD       26
`define LPM_W_RTC       29
`define LPM_W_MODE      32
`define LPM_BOOT_CYC    2'h3
`endif

// *** logic/lpm_pkg.sv ***
// Types of the low power mode controller
// Assumes nothing beyond a SystemVerilog compiler
package lpm_pkg;
	typedef enum logic [2:0] {
		ST_BOOT, ST_RUN, ST_BKGD, ST_WAIT, ST_STOP3, ST_STOP2
	} mode_t;
	typedef enum logic [2:0] {
		CMD_MEM, CMD_MEM_STAT, CMD_DBGREG, CMD_BACKGROUND,
		CMD_CPUREG, CMD_TRACE, CMD_GO
	} cmd_t;
endpackage

// *** verification/host_model.sv ***
// Stand-in for the CPU core and the debug host: turns a bench op code
// into the one-cycle strobes that the core or the host would give
// Assumes go and op change right after a rising edge of aclk
`timescale 1ns/100ps
module host_model (
	// Clock and request from the bench
	input  wire logic       aclk,
	input  wire logic       go,
	input  wire logic [3:0] op,
	// Core and debug strobes
	output logic            wait_insn,
	output logic            stop_insn,
	output logic            enter_debug_instruction,
	output logic            bdc_breakpoint,
	output logic            dbg_breakpoint,
	output logic            cmd_valid,
	output lpm_pkg::cmd_t   cmd
);
	import lpm_pkg::*;
	always_ff @(posedge aclk) begin
		cmd_valid <= go && op < 4'h7;
		wait_insn <= go && op == 4'h7;
		stop_insn <= go && op == 4'h8;
		enter_debug_instruction <= go && op == 4'h9;
		bdc_breakpoint <= go && op == 4'hA;
		dbg_breakpoint <= go && op == 4'hB;
	end
	// Between commands the code churns, so a stale code is never trusted
	always_ff @(posedge aclk) begin
		if (go && op < 4'h7)
			cmd <= cmd_t'(op[2:0]);
		else
			cmd <= cmd_t'(3'(cmd + 3'h1));
	end
endmodule

// *** verification/test_low_power_mode_controller.sv ***
// Self-checking bench for the low power mode controller
// Assumes host_model drives the core strobes and debug commands
`timescale 1ns/100ps
`include "lpm_cfg.svh"
module test_low_power_mode_controller;
	import lpm_pkg::*;
	localparam logic [2:0] OK = 3'h1, ER = 3'h2, RJ = 3'h4;
	logic        aclk, aresetn, ce, go, cmd_data, irq_req, rtc_wake;
	logic [3:0]  op, s_wstrb;
	logic [7:0]  s_awaddr, s_araddr;
	logic [27:0] wk;
	logic [31:0] s_wdata, s_rdata, d;
	logic [1:0]  r, s_bresp, s_rresp;
	logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic        debug_mode_select_pin, reset_pin_n, irq_pin_n;
	logic        low_supply_detector;
	logic        wait_insn, stop_insn, enter_debug_instruction;
	logic        bdc_breakpoint, dbg_breakpoint, cmd_valid;
	cmd_t        cmd;
	logic        cmd_ok, cmd_err, cmd_reject, cpu_clk_en, cpu_reset;
	logic        imask_clear, irq_stack_start, illegal_reset, cpu_step;
	logic        periph_clk_en, debug_clk_en, regulator_full;
	logic        power_off, pin_hold, lv_trip_high;
	int          failures, checks, n_ims, n_stk, n_ill, n_step, i, w;
	logic [2:0]  expq[$];
	logic [8:0]  cs[4] = '{9'h111, 9'h113, 9'h01F, 9'h003};

	host_model host (.aclk, .go, .op, .wait_insn, .stop_insn,
		.enter_debug_instruction, .bdc_breakpoint, .dbg_breakpoint,
		.cmd_valid, .cmd);
	low_power_mode_controller dut (.aclk, .aresetn, .ce, .s_awaddr,
		.s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
		.s_rdata, .s_rresp, .s_rvalid, .s_rready, .debug_mode_select_pin,
		.reset_pin_n, .irq_pin_n, .port_a_pin_interrupts(wk[7:0]),
		.port_b_pin_interrupts(wk[15:8]), .port_d_pin_interrupts(wk[23:16]),
		.low_supply_detector, .low_supply_warning(wk[24]),
		.adc_done(wk[25]), .rtc_wake, .can_wake(wk[26]),
		.sci_rx_irq(wk[27]), .wait_insn, .stop_insn,
		.enter_debug_instruction, .irq_req, .cpu_clk_en, .cpu_reset,
		.imask_clear, .irq_stack_start, .illegal_reset, .cpu_step,
		.bdc_breakpoint, .dbg_breakpoint, .cmd_valid, .cmd, .cmd_data,
		.cmd_ok, .cmd_err, .cmd_reject, .periph_clk_en, .debug_clk_en,
		.regulator_full, .power_off, .pin_hold, .lv_trip_high);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic hang();
		failures++;
		$display("wrong value bus answer expected 1 seen 0");
		stop_test();
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] v);
		logic ta, tw, tb;
		int k;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge aclk);
			ta = s_awvalid && s_awready;
			tw = s_wvalid && s_wready;
			tb = s_bvalid;
			r = s_bresp;
			@(posedge aclk);
			if (ta)
				s_awvalid <= 1'b0;
			if (tw)
				s_wvalid <= 1'b0;
			if (tb) begin
				s_bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task automatic rd(logic [7:0] a);
		logic ta, tr;
		int k;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge aclk);
			ta = s_arvalid && s_arready;
			tr = s_rvalid;
			d = s_rdata;
			r = s_rresp;
			@(posedge aclk);
			if (ta)
				s_arvalid <= 1'b0;
			if (tr) begin
				s_rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	// Wake paths pass a synchroniser, so the mode is polled, not timed
	task automatic st(logic [2:0] e);
		int k;
		for (k = 0; k < 30; k++) begin
			rd(`LPM_OFF_STATUS);
			if (d[2:0] === e)
				break;
		end
		check("mode", d[2:0], e);
	endtask

	task automatic cmd_do(logic [3:0] o, logic [2:0] e);
		@(posedge aclk);
		if (e != 3'h0)
			expq.push_back(e);
		op <= o;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask

	task automatic tdone(string s);
		$display("test %s done", s);
	endtask

	// Answers and strobes are registered, so they are read mid-cycle
	always @(negedge aclk) begin
		if (aresetn === 1'b1) begin
			n_ims += (imask_clear === 1'b1);
			n_stk += (irq_stack_start === 1'b1);
			n_ill += (illegal_reset === 1'b1);
			n_step += (cpu_step === 1'b1);
			if ({cmd_reject, cmd_err, cmd_ok} !== 3'h0) begin
				if (expq.size() == 0)
					check("answer", {cmd_reject, cmd_err, cmd_ok}, 0);
				else
					check("answer", {cmd_reject, cmd_err, cmd_ok}, expq.pop_front());
			end
		end
	end

	initial begin
		void'($urandom(26386));
		{aresetn, go, irq_req, cmd_data, rtc_wake, low_supply_detector} = '0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{op, wk, s_awaddr, s_araddr, s_wdata} = '0;
		{ce, reset_pin_n, irq_pin_n} = 3'h7;
		s_wstrb = 4'hF;
		debug_mode_select_pin = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(`LPM_OFF_CTRL);
		check("ctrl reset", d, `LPM_CTRL_RST);
		st(3'h2);
		check("cpu clock", cpu_clk_en, 1'b0);
		debug_mode_select_pin <= 1'b1;
		for (i = 0; i < 6; i++)
			cmd_do(4'(i), OK);
		check("steps", n_step, 1);
		cmd_do(4'h6, OK);
		st(3'h1);
		check("cpu clock", cpu_clk_en, 1'b1);
		tdone("background");
		for (i = 0; i < 7; i++)
			if (i != 3)
				cmd_do(4'(i), i < 3 ? OK : RJ);
		foreach (cs[j]) begin
			cmd_do(j == 0 ? 4'h3 : 4'(8 + j), j == 0 ? OK : 3'h0);
			st(3'h2);
			cmd_do(4'h6, OK);
			st(3'h1);
		end
		tdone("run commands");
		cmd_do(4'h7, 3'h0);
		st(3'h3);
		check("mask clears", n_ims, 1);
		cmd_do(4'h1, ER);
		cmd_do(4'h0, RJ);
		irq_req <= 1'b1;
		st(3'h1);
		irq_req <= 1'b0;
		check("stackings", n_stk, 1);
		cmd_do(4'h7, 3'h0);
		cmd_do(4'h3, OK);
		st(3'h2);
		cmd_do(4'h6, OK);
		cmd_do(4'h8, 3'h0);
		st(3'h1);
		check("illegal resets", n_ill, 1);
		tdone("wait");
		foreach (cs[j]) begin
			cmd_do(4'h3, OK);
			cmd_data <= cs[j][8];
			cmd_do(4'h2, OK);
			cmd_do(4'h6, OK);
			wr(`LPM_OFF_CTRL, 32'(cs[j][3:0]));
			cmd_do(4'h8, 3'h0);
			st(3'h4);
			check("debug clock", debug_clk_en, cs[j][8]);
			check("regulator", regulator_full, cs[j][4]);
			check("periph clock", periph_clk_en, 1'b0);
			if (cs[j][8]) begin
				cmd_do(4'h1, ER);
				cmd_do(4'h3, OK);
				st(3'h2);
				cmd_do(4'h6, OK);
			end else begin
				cmd_do(4'h3, RJ);
				w = n_stk;
				wk[$urandom % 28] <= 1'b1;
				st(3'h1);
				wk <= '0;
				check("stackings", n_stk, w + 1);
			end
		end
		cmd_do(4'h8, 3'h0);
		st(3'h4);
		reset_pin_n <= 1'b0;
		repeat (8) @(posedge aclk);
		reset_pin_n <= 1'b1;
		st(3'h1);
		tdone("shallow stop");
		for (w = 0; w < 3; w++) begin
			wr(`LPM_OFF_CTRL, 32'h0000_0009 | (32'h0000_0008 << w));
			cmd_do(4'h8, 3'h0);
			st(3'h5);
			check("hold", {power_off, pin_hold}, 2'h3);
			reset_pin_n <= (w != 0);
			rtc_wake <= (w == 1);
			irq_pin_n <= (w != 2);
			repeat (8) @(posedge aclk);
			{reset_pin_n, rtc_wake, irq_pin_n} <= 3'h5;
			st(3'h1);
			check("trip", lv_trip_high, 1'b0);
			rd(`LPM_OFF_STATUS);
			check("flags", d[5:3], 3'h3);
			rd(`LPM_OFF_CTRL);
			check("ctrl", d, 0);
			wr(`LPM_OFF_ACK, 32'h0000_0001);
			rd(`LPM_OFF_STATUS);
			check("flags", d[4:3], 2'h0);
			check("pin hold", pin_hold, 1'b0);
		end
		tdone("deep stop");
		wr(`LPM_OFF_CTRL, 32'h0000_007F);
		rd(`LPM_OFF_CTRL);
		check("ctrl", d, 32'h0000_007F);
		check("trip", lv_trip_high, 1'b1);
		rd(`LPM_OFF_ACK);
		check("ack read", d, 0);
		wr(8'h10, 32'h0000_0001);
		check("bresp", r, 2'h2);
		rd(8'h10);
		check("rresp", r, 2'h2);
		check("rdata", d, 32'h0000_0000);
		check("left over", expq.size(), 0);
		tdone("registers");
		stop_test();
	end
endmodule
